// File: shared/two_wire_defs.svh
// constants of the two-wire slave status and interrupt block
// Functional notes
// - receive data shows last byte while ready
// - holding write sends byte as transmitter
// - check value updates per byte, clears at stop
// - writing one to clear bit clears flag
// - bit 23 set on each byte done
// - bit 22 set on repeated start
// - bit 21 set on stop
// - bits 20..16 set per address match type
// - bit 14 set on misplaced start/stop
// - bit 13 set on check value mismatch
// - bit 12 set on bus timeout
// - bit 8 set on master NAK
// - bit 7 set on receive overrun
// - bit 6 set on transmit underrun
// - bit 5 shows transmitter direction
// - bit 3 set at stop after addressed
// - bit 2 shows slave enabled
// - bit 1 shows transmit buffer free
// - bit 0 shows receive data waiting
// - enable-set write ones set mask bits
// - enable-clear write ones clear mask bits
// - hold clock low instead of over/underrun
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH
// register offsets
`define OFF_CTRL     8'h00
`define OFF_RHR      8'h0C
`define OFF_THR      8'h10
`define OFF_PEC      8'h14
`define OFF_STATUS   8'h18
`define OFF_IEN_SET  8'h1C
`define OFF_IEN_CLR  8'h20
`define OFF_IMASK    8'h24
`define OFF_SCLR     8'h28
// status bit positions
`define SB_BTF    23
`define SB_REP    22
`define SB_STO    21
`define SB_HIT_HI 20
`define SB_HIT_LO 16
`define SB_MISPLACED_CONDITION_FLAG 14
`define SB_PECERR 13
`define SB_TOUT   12
`define SB_NAK    8
`define SB_RX_OVERFLOW_FLAG   7
`define SB_TX_STARVED_FLAG   6
`define SB_DIR    5
`define SB_TRANSACTION_DONE_FLAG  3
`define SB_SEN    2
`define SB_TXFREE 1
`define SB_RXFULL 0
// control bit positions
`define CB_EN     0
`define CB_SMB    1
`define CB_OWN    2
`define CB_GC     3
`define CB_HOLD   4
`define CB_DEF    5
`define CB_HH     6
`define CB_ALERT  7
`define CB_PEC    8
`define CB_AD_HI  22
`define CB_AD_LO  16
// reset values and masks
`define STATUS_RESET 32'h00000002
`define STICKY_MASK  32'h00FF71C8
`define IMASK_MASK   32'h00FF71CB
`define CTRL_MASK    32'h007F01FF
// fixed bus addresses
`define ADDR_GCALL   7'h00
`define ADDR_DEFAULT 7'h61
`define ADDR_HOST    7'h08
`define ADDR_ALERT   7'h0C
// timing
`define CLK_MHZ     125
`define TIMEOUT_US  25000
`endif

// File: shared/two_wire_pkg.sv
// types of the two-wire slave status and interrupt block
package two_wire_pkg;
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX       = 3'b011,
    ST_RX_ACK   = 3'b100,
    ST_TX       = 3'b101,
    ST_TX_ACK   = 3'b110,
    ST_TX_LOAD  = 3'b111
  } link_state_e;
  typedef logic [7:0] byte_t;
endpackage

// File: shared/line_events_if.sv
// synchronised bus levels and edge events between conditioner and engine
`timescale 1ns/10ps
interface line_events_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, sda, scl_rise, scl_fall, start, stop);
  modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// File: hdl/line_conditioner.sv
// two-flop synchroniser and start/stop/edge detector for the bus pins
`timescale 1ns/10ps
module line_conditioner (
  input  wire logic    ref_clk,
  input  wire logic    rst_n,
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  line_events_if.src   ln
);
  logic scl_m_r;
  logic sda_m_r;
  logic scl_s_r;
  logic sda_s_r;
  logic scl_p_r;
  logic sda_p_r;

  // first stage feeds only the second; third stage keeps last level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_r <= 1'b1;
      sda_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_m_r <= scl_in;
      sda_m_r <= sda_in;
      scl_s_r <= scl_m_r;
      sda_s_r <= sda_m_r;
      scl_p_r <= scl_s_r;
      sda_p_r <= sda_s_r;
    end
  end

  // edges of the clock line, data changes while clock stays high
  assign ln.scl      = scl_s_r;
  assign ln.sda      = sda_s_r;
  assign ln.scl_rise = scl_s_r & ~scl_p_r;
  assign ln.scl_fall = ~scl_s_r & scl_p_r;
  assign ln.start    = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
  assign ln.stop     = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
endmodule // line_conditioner

// File: hdl/two_wire_slave_status_irq.sv
// two-wire slave: register file, byte engine, status flags and interrupt
`timescale 1ns/10ps
`include "two_wire_defs.svh"
module two_wire_slave_status_irq
  import two_wire_pkg::*;
#(
  parameter int ADDR_W      = 8,
  parameter int TIMEOUT_CYC = `TIMEOUT_US * `CLK_MHZ
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic                   irq,
  input  wire logic              scl_in,
  output logic                   scl_out,
  output logic                   scl_oe_n,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  if (ADDR_W < 6 || TIMEOUT_CYC < 2) begin : bad_param
    $error("address width or timeout count too small");
  end

  line_events_if ln ();

  line_conditioner u_cond (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .ln      (ln)
  );

  link_state_e   st_r;
  logic [3:0]    cnt_r;
  byte_t         sh_r;
  byte_t         txb_r;
  byte_t         rx_data_r;
  byte_t         tx_hold_r;
  byte_t         crc_r;
  logic          dir_r;
  logic          addressed_r;
  logic          busy_r;
  logic          hold_r;
  logic          sda_rel_r;
  logic          rx_load_r;
  logic          tx_take_r;
  logic          rx_full_r;
  logic          tx_free_r;
  logic [31:0]   ev_set_r;
  logic [31:0]   sticky_r;
  logic [31:0]   imr_r;
  logic [31:0]   ctrl_r;
  logic [31:0]   status;
  logic [TW-1:0] tmo_cnt_r;
  logic [4:0]    hit;
  logic [6:0]    rx_addr;
  logic          act;
  logic          mid_byte;
  logic          tmo_hit;
  logic          slave_on;
  logic          hold_en;
  logic          wr_thr;
  logic          rd_rhr;
  logic          wr_sclr;
  logic          wr_iset;
  logic          wr_iclr;

  // one-hot address compare shared by read and write decode
  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    at = (a == ADDR_W'(off));
  endfunction

  // bytewise crc with polynomial x^8+x^2+x+1
  function automatic byte_t crc8(input byte_t c, input byte_t d);
    byte_t x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    end
    crc8 = x;
  endfunction

  // decoded strobes and control fields
  assign wr_thr   = reg_wr && at(reg_addr, `OFF_THR);
  assign rd_rhr   = reg_rd && at(reg_addr, `OFF_RHR);
  assign wr_sclr  = reg_wr && at(reg_addr, `OFF_SCLR);
  assign wr_iset  = reg_wr && at(reg_addr, `OFF_IEN_SET);
  assign wr_iclr  = reg_wr && at(reg_addr, `OFF_IEN_CLR);
  assign slave_on = ctrl_r[`CB_EN];
  assign hold_en  = ctrl_r[`CB_HOLD];
  assign act      = ln.scl_fall || hold_r;
  assign tmo_hit  = busy_r && (tmo_cnt_r == TW'(TIMEOUT_CYC - 1));
  // the clock rise of a proper stop or restart counts as one bit, so two or more is misplaced
  assign mid_byte = (cnt_r > 4'd1) && (st_r inside {ST_ADDR, ST_RX, ST_TX});
  assign rx_addr  = sh_r[7:1];

  // address match per type: default, host header, alert, general call, own
  assign hit[4] = ctrl_r[`CB_SMB] && ctrl_r[`CB_DEF] && rx_addr == `ADDR_DEFAULT;
  assign hit[3] = ctrl_r[`CB_SMB] && ctrl_r[`CB_HH] && rx_addr == `ADDR_HOST;
  assign hit[2] = ctrl_r[`CB_SMB] && ctrl_r[`CB_ALERT] && rx_addr == `ADDR_ALERT;
  assign hit[1] = ctrl_r[`CB_GC] && rx_addr == `ADDR_GCALL && !sh_r[0];
  assign hit[0] = ctrl_r[`CB_OWN] && rx_addr == ctrl_r[`CB_AD_HI:`CB_AD_LO];

  // live status word: sticky flags plus state bits
  always_comb begin
    status               = sticky_r;
    status[`SB_DIR]      = dir_r;
    status[`SB_SEN]      = slave_on;
    status[`SB_TXFREE]   = tx_free_r;
    status[`SB_RXFULL]   = rx_full_r;
  end

  // low time of the clock line while a transfer is open
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_cnt_r <= '0;
    end else if (busy_r && !ln.scl && !tmo_hit) begin
      tmo_cnt_r <= tmo_cnt_r + TW'(1);
    end else begin
      tmo_cnt_r <= '0;
    end
  end

  // byte engine: address, receive, transmit, acknowledge and clock hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r        <= ST_IDLE;
      cnt_r       <= 4'h0;
      sh_r        <= 8'h00;
      txb_r       <= 8'hFF;
      rx_data_r   <= 8'h00;
      crc_r       <= 8'h00;
      dir_r       <= 1'b0;
      addressed_r <= 1'b0;
      busy_r      <= 1'b0;
      hold_r      <= 1'b0;
      sda_rel_r   <= 1'b1;
      rx_load_r   <= 1'b0;
      tx_take_r   <= 1'b0;
      ev_set_r    <= 32'h0;
    end else begin
      ev_set_r  <= 32'h0;
      rx_load_r <= 1'b0;
      tx_take_r <= 1'b0;
      if (!slave_on) begin
        st_r        <= ST_IDLE;
        busy_r      <= 1'b0;
        addressed_r <= 1'b0;
        dir_r       <= 1'b0;
        hold_r      <= 1'b0;
        sda_rel_r   <= 1'b1;
      end else if (ln.stop) begin
        ev_set_r[`SB_STO]    <= 1'b1;
        ev_set_r[`SB_TRANSACTION_DONE_FLAG]  <= addressed_r;
        ev_set_r[`SB_MISPLACED_CONDITION_FLAG] <= mid_byte;
        ev_set_r[`SB_PECERR] <= ctrl_r[`CB_PEC] && addressed_r
                                && !dir_r && crc_r != 8'h00;
        crc_r       <= 8'h00;
        st_r        <= ST_IDLE;
        busy_r      <= 1'b0;
        addressed_r <= 1'b0;
        dir_r       <= 1'b0;
        hold_r      <= 1'b0;
        sda_rel_r   <= 1'b1;
      end else if (ln.start) begin
        ev_set_r[`SB_REP]    <= busy_r;
        ev_set_r[`SB_MISPLACED_CONDITION_FLAG] <= mid_byte;
        st_r        <= ST_ADDR;
        cnt_r       <= 4'h0;
        busy_r      <= 1'b1;
        addressed_r <= 1'b0;
        dir_r       <= 1'b0;
        hold_r      <= 1'b0;
        sda_rel_r   <= 1'b1;
      end else if (tmo_hit) begin
        ev_set_r[`SB_TOUT] <= 1'b1;
        st_r      <= ST_IDLE;
        busy_r    <= 1'b0;
        hold_r    <= 1'b0;
        sda_rel_r <= 1'b1;
      end else begin
        // every data bit is sampled on the rising clock edge
        if (ln.scl_rise && cnt_r < 4'd8 && st_r inside {ST_ADDR, ST_RX, ST_TX}) begin
          sh_r  <= {sh_r[6:0], ln.sda};
          cnt_r <= cnt_r + 4'd1;
        end
        unique case (st_r)
          ST_IDLE: begin
            sda_rel_r <= 1'b1;
          end
          ST_ADDR: begin
            if (ln.scl_fall && cnt_r == 4'd8) begin
              if (hit != 5'b0) begin
                ev_set_r[`SB_HIT_HI:`SB_HIT_LO] <= hit;
                ev_set_r[`SB_BTF] <= 1'b1;
                crc_r       <= crc8(crc_r, sh_r);
                addressed_r <= 1'b1;
                dir_r       <= sh_r[0];
                sda_rel_r   <= 1'b0;
                st_r        <= ST_ADDR_ACK;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_RX: begin
            if (act && cnt_r == 4'd8) begin
              if (rx_full_r && hold_en) begin
                hold_r <= 1'b1;
              end else begin
                hold_r <= 1'b0;
                ev_set_r[`SB_RX_OVERFLOW_FLAG] <= rx_full_r;
                ev_set_r[`SB_BTF]  <= 1'b1;
                rx_data_r <= sh_r;
                rx_load_r <= 1'b1;
                crc_r     <= crc8(crc_r, sh_r);
                sda_rel_r <= 1'b0;
                st_r      <= ST_RX_ACK;
              end
            end
          end
          ST_RX_ACK: begin
            if (ln.scl_fall) begin
              sda_rel_r <= 1'b1;
              cnt_r     <= 4'h0;
              st_r      <= ST_RX;
            end
          end
          ST_ADDR_ACK, ST_TX_LOAD: begin
            if (act) begin
              if (!dir_r) begin
                sda_rel_r <= 1'b1;
                cnt_r     <= 4'h0;
                st_r      <= ST_RX;
              end else if (tx_free_r && hold_en) begin
                hold_r <= 1'b1;
              end else begin
                hold_r <= 1'b0;
                ev_set_r[`SB_TX_STARVED_FLAG] <= tx_free_r;
                txb_r     <= tx_free_r ? 8'hFF : tx_hold_r;
                sda_rel_r <= tx_free_r ? 1'b1 : tx_hold_r[7];
                tx_take_r <= !tx_free_r;
                cnt_r     <= 4'h0;
                st_r      <= ST_TX;
              end
            end
          end
          ST_TX: begin
            if (ln.scl_fall) begin
              if (cnt_r == 4'd8) begin
                sda_rel_r <= 1'b1;
                st_r      <= ST_TX_ACK;
              end else begin
                sda_rel_r <= txb_r[3'(4'd7 - cnt_r)];
              end
            end
          end
          ST_TX_ACK: begin
            if (ln.scl_rise) begin
              ev_set_r[`SB_BTF] <= 1'b1;
              ev_set_r[`SB_NAK] <= ln.sda;
              crc_r <= crc8(crc_r, sh_r);
              st_r  <= ln.sda ? ST_IDLE : ST_TX_LOAD;
            end
          end
        endcase
      end
    end
  end

  // pin drivers: open drain, enable low while pulling the line low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_out  <= 1'b0;
      scl_out  <= 1'b0;
    end else begin
      sda_oe_n <= sda_rel_r;
      scl_oe_n <= !hold_r;
      sda_out  <= 1'b0;
      scl_out  <= 1'b0;
    end
  end

  // receive buffer state: engine load wins over a same-cycle read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_full_r <= 1'b0;
    end else if (rx_load_r) begin
      rx_full_r <= 1'b1;
    end else if (rd_rhr) begin
      rx_full_r <= 1'b0;
    end
  end

  // transmit holding register and its free flag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold_r <= 8'h00;
      tx_free_r <= 1'b1;
    end else if (wr_thr) begin
      tx_hold_r <= reg_wdata[7:0];
      tx_free_r <= 1'b0;
    end else if (tx_take_r) begin
      tx_free_r <= 1'b1;
    end
  end

  // sticky flags: a set in the same cycle beats a clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sticky_r <= 32'h0;
    end else begin
      sticky_r <= ((sticky_r & ~(wr_sclr ? reg_wdata : 32'h0)) | ev_set_r)
                  & `STICKY_MASK;
    end
  end

  // control and interrupt mask registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= 32'h0;
      imr_r  <= 32'h0;
    end else begin
      if (reg_wr && at(reg_addr, `OFF_CTRL)) begin
        ctrl_r <= reg_wdata & `CTRL_MASK;
      end
      if (wr_iset) begin
        imr_r <= imr_r | (reg_wdata & `IMASK_MASK);
      end else if (wr_iclr) begin
        imr_r <= imr_r & ~reg_wdata;
      end
    end
  end

  // read data one cycle after the strobe; unmapped and idle read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h0;
    end else if (at(reg_addr, `OFF_CTRL)) begin
      reg_rdata <= ctrl_r;
    end else if (at(reg_addr, `OFF_RHR)) begin
      reg_rdata <= {24'h0, rx_data_r};
    end else if (at(reg_addr, `OFF_PEC)) begin
      reg_rdata <= {24'h0, crc_r};
    end else if (at(reg_addr, `OFF_STATUS)) begin
      reg_rdata <= status;
    end else if (at(reg_addr, `OFF_IMASK)) begin
      reg_rdata <= imr_r;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // interrupt request from flagged and unmasked status bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & imr_r);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  mask_set_a: assert property (wr_iset |=> ((imr_r & $past(reg_wdata & `IMASK_MASK))
    == $past(reg_wdata & `IMASK_MASK))) else $error("mask bit not set");
  mask_clear_a: assert property (wr_iclr |=> ((imr_r & $past(reg_wdata)) == 32'h0))
    else $error("mask bit not cleared");
  flag_clear_a: assert property (wr_sclr |=> ((sticky_r & $past(reg_wdata & ~ev_set_r))
    == 32'h0)) else $error("flag survived clear");
  flag_hold_a: assert property (!wr_sclr && ev_set_r == 32'h0 |=> $stable(sticky_r))
    else $error("flag changed without cause");
  stop_flag_a: assert property (slave_on && ln.stop |-> ##2 sticky_r[`SB_STO])
    else $error("stop not flagged");
  pec_clear_a: assert property (slave_on && ln.stop |=> crc_r == 8'h00)
    else $error("check value not cleared at stop");
  rx_view_a: assert property (rd_rhr && rx_full_r |=> reg_rdata == {24'h0, $past(rx_data_r)})
    else $error("receive byte not shown");
  tx_busy_a: assert property (wr_thr |=> !tx_free_r && tx_hold_r == $past(reg_wdata[7:0]))
    else $error("holding write not taken");
  dir_read_a: assert property (reg_rd && at(reg_addr, `OFF_STATUS) |=>
    reg_rdata[`SB_DIR] == $past(dir_r) && reg_rdata[`SB_SEN] == $past(slave_on))
    else $error("direction or enable wrong");
  hold_pin_a: assert property (hold_r |=> !scl_oe_n)
    else $error("clock not held");
  irq_follow_a: assert property ($rose(|(status & imr_r)) |=> irq ##1 irq || !(|(status & imr_r)))
    else $error("interrupt not raised");
endmodule // two_wire_slave_status_irq

// File: verification/bus_master_model.sv
// open-drain two-wire bus master model that drives frames on request
`timescale 1ns/10ps
module bus_master_model (
  input  wire logic scl_w,
  input  wire logic sda_w,
  output logic      scl_rel,
  output logic      sda_rel,
  output logic      stall_err
);
  int n;
  // lines released at time zero so the pull-ups hold them high
  initial begin
    scl_rel = 1'b1;
    sda_rel = 1'b1;
    stall_err = 1'b0;
  end
  // one bit: data set while clock low, clock released, bounded wait for stretch
  task automatic clk_bit(input logic b, output logic r);
    sda_rel = b;
    #31 scl_rel = 1'b1;
    for (n = 0; n < 4000 && scl_w !== 1'b1; n++) #8;
    if (scl_w !== 1'b1) stall_err = 1'b1;
    #31 r = sda_w;
    #31 scl_rel = 1'b0;
    #31;
  endtask
  // data falls while clock high; also used as a repeated start
  task automatic start_cond();
    sda_rel = 1'b1;
    #31 scl_rel = 1'b1;
    #31 sda_rel = 1'b0;
    #31 scl_rel = 1'b0;
    #31;
  endtask
  // data rises while clock high
  task automatic stop_cond();
    sda_rel = 1'b0;
    #31 scl_rel = 1'b1;
    #31 sda_rel = 1'b1;
    #31;
  endtask
  // msb first, then the ninth clock returns the slave's ack level
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) clk_bit(b[i], ack);
    clk_bit(1'b1, ack);
  endtask
  // byte from the slave, then master ack (0) or nak (1)
  task automatic recv_byte(input logic nak, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
    clk_bit(nak, r);
  endtask
endmodule // bus_master_model

// File: verification/test_two_wire_slave_status_irq.sv
// self-checking bench for the two-wire slave status and interrupt block
`timescale 1ns/10ps
`include "two_wire_defs.svh"
module test_two_wire_slave_status_irq;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic        ref_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        scl_out;
  logic        scl_oe_n;
  logic        sda_out;
  logic        sda_oe_n;
  logic        scl_rel;
  logic        sda_rel;
  logic        stall_err;
  logic        ack;
  logic [7:0]  rb;
  int          mismatches;
  int          checks;
  // wired-and of both parties with pull-ups
  wire         scl_w = scl_rel & scl_oe_n;
  wire         sda_w = sda_rel & sda_oe_n;

  two_wire_slave_status_irq #(.ADDR_W(8), .TIMEOUT_CYC(200)) two_wire_slave_status_irq_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  bus_master_model bus_master_model_inst (.scl_w(scl_w), .sda_w(sda_w),
    .scl_rel(scl_rel), .sda_rel(sda_rel), .stall_err(stall_err));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data judged in the following cycle under a mask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction

  // reset values, read-only, unmapped, mask set and clear, interrupt line
  task automatic t_regs();
    rdc(8'h18, ALL, 32'h00000002);
    rdc(8'h40, ALL, 32'h00000000);
    wr(8'h18, ALL);
    rdc(8'h18, ALL, 32'h00000002);
    wr(8'h1C, ALL);
    rdc(8'h24, ALL, `IMASK_MASK);
    cyc(2);
    #1 chk({31'h0, irq}, 32'h00000001);
    wr(8'h20, 32'h00000002);
    wr(8'h1C, 32'h00000001);
    rdc(8'h24, ALL, 32'h00FF71C9);
    cyc(2);
    #1 chk({31'h0, irq}, 32'h00000000);
    wr(8'h20, ALL);
    rdc(8'h24, ALL, 32'h00000000);
  endtask
  // write frame with running check value, stop flags and flag clearing
  task automatic t_write();
    logic [7:0] c;
    c = crc8(crc8(8'h00, 8'h54), 8'hA5);
    wr(8'h00, 32'h002A01EF);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.send_byte(8'h54, ack);
    chk({31'h0, ack}, 32'h00000000);
    bus_master_model_inst.send_byte(8'hA5, ack);
    rdc(8'h14, ALL, {24'h0, c});
    bus_master_model_inst.stop_cond();
    cyc(8);
    rdc(8'h18, ALL, 32'h00A1000F | (c != 8'h00 ? 32'h2000 : 32'h0));
    rdc(8'h14, ALL, 32'h00000000);
    rdc(8'h0C, ALL, 32'h000000A5);
    rdc(8'h18, 32'h00000001, 32'h00000000);
    wr(8'h28, `STICKY_MASK);
    rdc(8'h18, ALL, 32'h00000006);
  endtask
  // second byte arrives before the first is read, clock hold off
  task automatic t_overrun();
    logic [7:0] c;
    c = crc8(crc8(crc8(8'h00, 8'h54), 8'h11), 8'h22);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.send_byte(8'h54, ack);
    bus_master_model_inst.send_byte(8'h11, ack);
    bus_master_model_inst.send_byte(8'h22, ack);
    bus_master_model_inst.stop_cond();
    cyc(8);
    rdc(8'h18, 32'h000020C1, 32'h00000081 | (c != 8'h00 ? 32'h2000 : 32'h0));
    rdc(8'h0C, ALL, 32'h00000022);
    wr(8'h28, `STICKY_MASK);
  endtask
  // clock hold on: second byte waits with the clock low until the first is read
  task automatic t_hold();
    wr(8'h00, 32'h002A01FF);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.send_byte(8'h54, ack);
    bus_master_model_inst.send_byte(8'h11, ack);
    fork
      bus_master_model_inst.send_byte(8'h22, ack);
      begin
        cyc(170);
        chk({31'h0, scl_w}, 32'h00000000);
        rdc(8'h0C, ALL, 32'h00000011);
      end
    join
    chk({31'h0, ack}, 32'h00000000);
    bus_master_model_inst.stop_cond();
    cyc(8);
    rdc(8'h18, 32'h00000081, 32'h00000001);
    rdc(8'h0C, ALL, 32'h00000022);
    wr(8'h28, `STICKY_MASK);
    wr(8'h00, 32'h002A01EF);
  endtask
  // read frame: one loaded byte, then an empty buffer and a nak
  task automatic t_read();
    wr(8'h10, 32'h000000C3);
    rdc(8'h18, 32'h00000002, 32'h00000000);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.send_byte(8'h55, ack);
    chk({31'h0, ack}, 32'h00000000);
    bus_master_model_inst.recv_byte(1'b0, rb);
    chk({24'h0, rb}, 32'h000000C3);
    rdc(8'h18, 32'h00000020, 32'h00000020);
    bus_master_model_inst.recv_byte(1'b1, rb);
    chk({24'h0, rb}, 32'h000000FF);
    bus_master_model_inst.stop_cond();
    cyc(8);
    rdc(8'h18, 32'h00000142, 32'h00000142);
    wr(8'h28, `STICKY_MASK);
  endtask
  // repeated start, clock held low past the timeout, then a cut-off byte
  task automatic t_cond();
    bus_master_model_inst.start_cond();
    bus_master_model_inst.send_byte(8'h54, ack);
    bus_master_model_inst.start_cond();
    bus_master_model_inst.send_byte(8'h54, ack);
    #2000;
    bus_master_model_inst.stop_cond();
    cyc(8);
    rdc(8'h18, 32'h00401000, 32'h00401000);
    bus_master_model_inst.start_cond();
    for (int i = 0; i < 3; i++) bus_master_model_inst.clk_bit(1'b0, ack);
    bus_master_model_inst.stop_cond();
    cyc(8);
    rdc(8'h18, 32'h00004000, 32'h00004000);
    wr(8'h28, `STICKY_MASK);
  endtask
  // every address type sets its own match flag only
  task automatic t_hits();
    logic [6:0] ad [5] = '{7'h2A, 7'h00, 7'h0C, 7'h08, 7'h61};
    for (int i = 0; i < 5; i++) begin
      bus_master_model_inst.start_cond();
      bus_master_model_inst.send_byte({ad[i], 1'b0}, ack);
      chk({31'h0, ack}, 32'h00000000);
      bus_master_model_inst.stop_cond();
      cyc(8);
      rdc(8'h18, 32'h001F0000, 32'h00000001 << (16 + i));
      wr(8'h28, `STICKY_MASK);
    end
  endtask

  // main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    checks = 0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(3);
    t_regs();
    t_write();
    t_overrun();
    t_hold();
    t_read();
    t_cond();
    t_hits();
    final_report();
  end
  // watchdog on the whole run and on a clock that never comes back
  initial begin
    for (int k = 0; k < 100000 && stall_err !== 1'b1; k++) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
endmodule // test_two_wire_slave_status_irq
